// ==== rtl/exec_unit.sv ====
// execution unit for sleep, rotate, subtract, swap, direction load and xor
// assumes a classic wishbone master; a write to the command word executes only while the core runs
//
// Contract
// RQ1 - sleep clears watchdog count and prescaler
// RQ2 - sleep sets timeout bit, clears powerdown bit
// RQ3 - sleep then halts the oscillator
// RQ4 - rotate left through carry, only carry changes
// RQ5 - rotate right through carry, only carry changes
// RQ6 - subtract accumulator from register, update c/dc/z
// RQ7 - destination bit 0 to accumulator, 1 register
// RQ8 - swap nibbles, no flags change
// RQ9 - accumulator loads direction register 6 or 7
// RQ10 - register xor, destination steered, zero only
// RQ11 - literal xor into accumulator, zero only
// RQ12 - zero on zero result; carries mean no borrow
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module exec_unit
  import exec_pkg::*;
#(
  parameter int FILE_DEPTH = 32
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire wb_req_t wb_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  output logic osc_run_out,
  output logic [7:0] dir_a_out,
  output logic [7:0] dir_b_out
);

  ////////////////////////////////////////////////////////////////////////
  // state

  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [7:0] w_r;
  logic [7:0] w_nxt;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] dir_a_r;
  logic [7:0] dir_a_nxt;
  logic [7:0] dir_b_r;
  logic [7:0] dir_b_nxt;
  core_state_t state_r;
  core_state_t state_nxt;
  logic [7:0] file_r [FILE_DEPTH];
  logic file_we;
  logic [4:0] file_idx;
  logic [7:0] file_data;

  logic commit;
  logic exec;
  logic [31:0] cmd;
  op_t cmd_op;
  logic cmd_d;
  logic [4:0] cmd_f;
  logic [7:0] cmd_k;
  logic [7:0] fval;
  alu_out_t alu;
  logic dog_clr;
  logic [7:0] dog_cnt;
  logic [7:0] dog_pre;

  ////////////////////////////////////////////////////////////////////////
  // command decode and datapath

  assign cmd = apply_sel(32'h0000_0000, wb_in.dat, wb_in.sel);
  assign cmd_op = op_t'(cmd[3:0]);
  assign cmd_d = cmd[CMD_D_BIT];
  assign cmd_f = cmd[CMD_F_LSB +: 5];
  assign cmd_k = cmd[CMD_K_LSB +: 8];
  assign fval = file_r[cmd_f];

  // writes land on the edge where the master sees ack, as the bus requires
  assign commit = wb_in.cyc & wb_in.stb & wb_in.we & ack_r;
  // while asleep the core clock is notionally stopped, so commands are dropped
  assign exec = commit && wb_in.adr == ADR_CMD && state_r == ST_RUN;
  assign dog_clr = exec && cmd_op == OP_SLEEP; // RQ1

  exec_alu u_alu (
    .op_in(cmd_op),
    .f_in(fval),
    .w_in(w_r),
    .k_in(cmd_k),
    .c_in(status_r[ST_C]),
    .res_out(alu)
  );

  exec_watchdog #(
    .PRE_W(8),
    .CNT_W(8)
  ) u_dog (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clr_in(dog_clr),
    .cnt_out(dog_cnt),
    .pre_out(dog_pre)
  );

  ////////////////////////////////////////////////////////////////////////
  // next values

  always_comb begin
    ack_nxt = wb_in.cyc & wb_in.stb & ~ack_r;
    dat_nxt = dat_r;
    w_nxt = w_r;
    status_nxt = status_r;
    dir_a_nxt = dir_a_r;
    dir_b_nxt = dir_b_r;
    state_nxt = state_r;
    file_we = 1'b0;
    file_idx = wb_in.adr[6:2];
    file_data = 8'(apply_sel({24'h000000, file_r[wb_in.adr[6:2]]},
                             wb_in.dat,
                             wb_in.sel));
    if (ack_nxt) begin
      if (wb_in.adr[FILE_SEL_BIT]) begin
        dat_nxt = {24'h000000, file_r[wb_in.adr[6:2]]};
      end else if (wb_in.adr == ADR_W) begin
        dat_nxt = {24'h000000, w_r};
      end else if (wb_in.adr == ADR_STATUS) begin
        dat_nxt = {24'h000000, status_r};
      end else if (wb_in.adr == ADR_DIR_A) begin
        dat_nxt = {24'h000000, dir_a_r};
      end else if (wb_in.adr == ADR_DIR_B) begin
        dat_nxt = {24'h000000, dir_b_r};
      end else if (wb_in.adr == ADR_DOG) begin
        dat_nxt = {16'h0000, dog_pre, dog_cnt};
      end else if (wb_in.adr == ADR_WAKE) begin
        dat_nxt = {31'h0000_0000, state_r == ST_ASLEEP};
      end else begin
        dat_nxt = 32'h0000_0000;
      end
    end
    if (commit) begin
      if (wb_in.adr[FILE_SEL_BIT]) begin
        file_we = 1'b1;
      end else if (wb_in.adr == ADR_W) begin
        w_nxt = 8'(apply_sel({24'h000000, w_r}, wb_in.dat, wb_in.sel));
      end else if (wb_in.adr == ADR_STATUS) begin
        status_nxt = 8'(apply_sel({24'h000000, status_r}, wb_in.dat,
                                  wb_in.sel));
      end else if (wb_in.adr == ADR_WAKE) begin
        if (wb_in.sel[0] && wb_in.dat[0]) begin
          state_nxt = ST_RUN;
        end
      end
    end
    if (exec) begin
      case (cmd_op)
        OP_SLEEP: begin
          status_nxt[ST_TIMEOUT] = TIMEOUT_ON_SLEEP; // RQ2
          status_nxt[ST_POWERDOWN] = POWERDOWN_ON_SLEEP; // RQ2
          state_nxt = ST_ASLEEP; // RQ3
        end
        OP_DIR_LOAD: begin
          if (cmd_f == DIR_A_IDX) begin
            dir_a_nxt = w_r; // RQ9
          end else if (cmd_f == DIR_B_IDX) begin
            dir_b_nxt = w_r; // RQ9
          end
        end
        default: begin
          if (alu.upd_c) begin
            status_nxt[ST_C] = alu.c;
          end
          if (alu.upd_hc) begin
            status_nxt[ST_HC] = alu.hc;
          end
          if (alu.upd_z) begin
            status_nxt[ST_Z] = alu.z;
          end
          if (alu.has_dest && cmd_d) begin
            file_we = 1'b1; // RQ7
            file_idx = cmd_f;
            file_data = alu.result;
          end else if (alu.has_dest || cmd_op == OP_XOR_K) begin
            w_nxt = alu.result; // RQ7
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      w_r <= W_RST;
      status_r <= STATUS_RST;
      dir_a_r <= DIR_RST;
      dir_b_r <= DIR_RST;
      state_r <= ST_RUN;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      w_r <= w_nxt;
      status_r <= status_nxt;
      dir_a_r <= dir_a_nxt;
      dir_b_r <= dir_b_nxt;
      state_r <= state_nxt;
    end
  end

  // no reset on the array keeps it mappable to plain ram
  always_ff @(posedge sys_clk_in) begin
    if (file_we) begin
      file_r[file_idx] <= file_data;
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = dat_r;
  assign osc_run_out = state_r == ST_RUN; // RQ3
  assign dir_a_out = dir_a_r;
  assign dir_b_out = dir_b_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  wdt_cleared_a: assert property ( // RQ1
    exec && cmd_op == OP_SLEEP |=> dog_cnt == 8'h00 && dog_pre == 8'h00)
    else $error("watchdog not cleared by sleep");

  sleep_status_a: assert property ( // RQ2
    exec && cmd_op == OP_SLEEP |=> status_r[ST_TIMEOUT]
      && !status_r[ST_POWERDOWN]
      && status_r[ST_WAKE] == $past(status_r[ST_WAKE])
      && status_r[2:0] == $past(status_r[2:0]))
    else $error("sleep status bits wrong");

  osc_halt_a: assert property ( // RQ3
    exec && cmd_op == OP_SLEEP |=> !osc_run_out ##1 !osc_run_out)
    else $error("oscillator still running after sleep");

  rot_left_a: assert property ( // RQ4
    exec && cmd_op == OP_ROT_L && !cmd_d |=>
      w_r == {$past(fval[6:0]), $past(status_r[ST_C])}
      && status_r[ST_C] == $past(fval[7])
      && status_r[ST_Z:ST_HC] == $past(status_r[ST_Z:ST_HC]))
    else $error("rotate left result wrong");

  rot_right_a: assert property ( // RQ5
    exec && cmd_op == OP_ROT_R && !cmd_d |=>
      w_r == {$past(status_r[ST_C]), $past(fval[7:1])}
      && status_r[ST_C] == $past(fval[0]))
    else $error("rotate right result wrong");

  sub_flags_a: assert property ( // RQ6
    exec && cmd_op == OP_SUB && !cmd_d |=>
      w_r == 8'($past(fval) - $past(w_r))
      && status_r[ST_C] == ($past(fval) >= $past(w_r))
      && status_r[ST_HC] == ($past(fval[3:0]) >= $past(w_r[3:0]))
      && status_r[ST_Z] == ($past(fval) == $past(w_r)))
    else $error("subtract result or flags wrong");

  dest_reg_a: assert property ( // RQ7
    exec && alu.has_dest && cmd_d |=>
      w_r == $past(w_r) && file_r[$past(cmd_f)] == $past(alu.result))
    else $error("destination bit not honoured");

  swap_nib_a: assert property ( // RQ8
    exec && cmd_op == OP_SWAP && !cmd_d |=>
      w_r == {$past(fval[3:0]), $past(fval[7:4])}
      && status_r == $past(status_r))
    else $error("swap wrong or flags touched");

  dir_load_a: assert property ( // RQ9
    exec && cmd_op == OP_DIR_LOAD && cmd_f == DIR_B_IDX |=>
      dir_b_out == $past(w_r) && dir_a_out == $past(dir_a_out)
      && status_r == $past(status_r))
    else $error("direction register load wrong");

  xor_reg_a: assert property ( // RQ10
    exec && cmd_op == OP_XOR_F && !cmd_d |=>
      w_r == ($past(w_r) ^ $past(fval))
      && status_r[ST_Z] == (w_r == 8'h00)
      && status_r[ST_HC:ST_C] == $past(status_r[ST_HC:ST_C]))
    else $error("register xor wrong");

  xor_lit_a: assert property ( // RQ11
    exec && cmd_op == OP_XOR_K |=>
      w_r == ($past(w_r) ^ $past(cmd_k))
      && status_r[ST_HC:ST_C] == $past(status_r[ST_HC:ST_C]))
    else $error("literal xor wrong");

  zero_flag_a: assert property ( // RQ12
    exec && alu.upd_z |=> status_r[ST_Z] == ($past(alu.result) == 8'h00))
    else $error("zero flag wrong");

  sleep_c: cover property (exec && cmd_op == OP_SLEEP);
  sub_borrow_c: cover property (exec && cmd_op == OP_SUB && !alu.c);
  wake_c: cover property (state_r == ST_ASLEEP ##1 state_r == ST_RUN);

endmodule : exec_unit
`default_nettype wire

// ==== rtl/exec_pkg.sv ====
// shared constants, types and helpers for the execution unit
// assumes a single 25 MHz core clock and a classic wishbone master
package exec_pkg;

  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_W = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_DIR_A = 8'h0c;
  localparam logic [7:0] ADR_DIR_B = 8'h10;
  localparam logic [7:0] ADR_DOG = 8'h14;
  localparam logic [7:0] ADR_WAKE = 8'h18;
  localparam int FILE_SEL_BIT = 7;

  localparam int ST_C = 0;
  localparam int ST_HC = 1;
  localparam int ST_Z = 2;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_WAKE = 7;

  localparam int CMD_D_BIT = 4;
  localparam int CMD_F_LSB = 8;
  localparam int CMD_K_LSB = 16;

  localparam logic [4:0] DIR_A_IDX = 5'h06;
  localparam logic [4:0] DIR_B_IDX = 5'h07;

  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [7:0] DOG_CLEAR = 8'h00;
  localparam logic TIMEOUT_ON_SLEEP = 1'b1;
  localparam logic POWERDOWN_ON_SLEEP = 1'b0;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_SLEEP = 4'h1,
    OP_ROT_L = 4'h2,
    OP_ROT_R = 4'h3,
    OP_SUB = 4'h4,
    OP_SWAP = 4'h5,
    OP_DIR_LOAD = 4'h6,
    OP_XOR_F = 4'h7,
    OP_XOR_K = 4'h8
  } op_t;

  typedef enum logic {
    ST_RUN = 1'b0,
    ST_ASLEEP = 1'b1
  } core_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic [7:0] result;
    logic c;
    logic hc;
    logic z;
    logic upd_c;
    logic upd_hc;
    logic upd_z;
    logic has_dest;
  } alu_out_t;

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

  function automatic logic [31:0] apply_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : apply_sel

endpackage : exec_pkg

// ==== rtl/exec_alu.sv ====
// combinational datapath for rotate, subtract, swap and exclusive or
// assumes operands are stable for the cycle in which the op commits
`timescale 1ns/100ps
`default_nettype none
module exec_alu
  import exec_pkg::*;
(
  input wire op_t op_in,
  input wire logic [7:0] f_in,
  input wire logic [7:0] w_in,
  input wire logic [7:0] k_in,
  input wire logic c_in,
  output var alu_out_t res_out
);

  logic [8:0] diff;
  logic [4:0] low_diff;

  always_comb begin
    res_out = '0;
    // subtraction as f + ~w + 1, carry out means no borrow
    diff = {1'b0, f_in} + {1'b0, ~w_in} + 9'h001; // RQ6
    low_diff = {1'b0, f_in[3:0]} + {1'b0, ~w_in[3:0]} + 5'h01; // RQ12
    case (op_in)
      OP_ROT_L: begin
        res_out.result = {f_in[6:0], c_in}; // RQ4
        res_out.c = f_in[7];
        res_out.upd_c = 1'b1;
        res_out.has_dest = 1'b1;
      end
      OP_ROT_R: begin
        res_out.result = {c_in, f_in[7:1]}; // RQ5
        res_out.c = f_in[0];
        res_out.upd_c = 1'b1;
        res_out.has_dest = 1'b1;
      end
      OP_SUB: begin
        res_out.result = diff[7:0]; // RQ6
        res_out.c = diff[8]; // RQ12
        res_out.hc = low_diff[4];
        res_out.z = is_zero(diff[7:0]);
        res_out.upd_c = 1'b1;
        res_out.upd_hc = 1'b1;
        res_out.upd_z = 1'b1;
        res_out.has_dest = 1'b1;
      end
      OP_SWAP: begin
        res_out.result = {f_in[3:0], f_in[7:4]}; // RQ8
        res_out.has_dest = 1'b1;
      end
      OP_XOR_F: begin
        res_out.result = w_in ^ f_in; // RQ10
        res_out.z = is_zero(w_in ^ f_in); // RQ12
        res_out.upd_z = 1'b1;
        res_out.has_dest = 1'b1;
      end
      OP_XOR_K: begin
        res_out.result = w_in ^ k_in; // RQ11
        res_out.z = is_zero(w_in ^ k_in);
        res_out.upd_z = 1'b1;
      end
      default: begin
        res_out = '0;
      end
    endcase
  end

endmodule : exec_alu
`default_nettype wire

// ==== rtl/exec_watchdog.sv ====
// watchdog count with its prescaler, both cleared by a pulse
// assumes clr_in is a one-cycle pulse from the core clock domain
`timescale 1ns/100ps
`default_nettype none
module exec_watchdog
  import exec_pkg::*;
#(
  parameter int PRE_W = 8,
  parameter int CNT_W = 8
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic clr_in,
  output logic [CNT_W-1:0] cnt_out,
  output logic [PRE_W-1:0] pre_out
);

  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    pre_nxt = pre_r + 1'b1;
    cnt_nxt = cnt_r;
    if (&pre_r) begin
      cnt_nxt = cnt_r + 1'b1;
    end
    // clear wins over counting so the count after the op is exactly zero
    if (clr_in) begin
      pre_nxt = '0; // RQ1
      cnt_nxt = CNT_W'(DOG_CLEAR); // RQ1
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_r <= '0;
      cnt_r <= '0;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign cnt_out = cnt_r;
  assign pre_out = pre_r;

endmodule : exec_watchdog
`default_nettype wire

// ==== verification/exec_unit_tb.sv ====
// self-checking bench for the execution unit, one task per scenario
// assumes the unit is the only wishbone slave and needs no far-side model
`timescale 1ns/100ps
`default_nettype none
module exec_unit_tb
  import exec_pkg::*;
;
  localparam logic [7:0] DOG_ADR = 8'h14;
  localparam logic [7:0] WAKE_ADR = 8'h18;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  wb_req_t wb_in = '0;
  logic wb_ack_out;
  logic [31:0] wb_dat_out;
  logic osc_run_out;
  logic [7:0] dir_a_out;
  logic [7:0] dir_b_out;
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] rd_v;

  always #20 sys_clk_in = ~sys_clk_in;

  exec_unit #(.FILE_DEPTH(32)) DUT (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .wb_in(wb_in),
    .wb_ack_out(wb_ack_out),
    .wb_dat_out(wb_dat_out),
    .osc_run_out(osc_run_out),
    .dir_a_out(dir_a_out),
    .dir_b_out(dir_b_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask : chk

  // ack and read data are taken at the rising edge where the slave acts
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    wb_in <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    @(posedge sys_clk_in);
    while (wb_ack_out !== 1'b1) begin
      n++;
      if (n > 16) begin
        mismatches++;
        $display("wrong value at %0t: bus access never answered", $time);
        stop_test();
      end
      @(posedge sys_clk_in);
    end
    rd = wb_dat_out;
    wb_in <= '0;
    // outputs launched by the ack edge are looked at once they have settled
    @(negedge sys_clk_in);
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    bus(1'b1, adr, dat, d);
  endtask : wr

  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp,
                      input string what);
    logic [31:0] d;
    bus(1'b0, adr, 32'h0, d);
    chk(d, exp, what);
  endtask : rchk

  task automatic exec(input op_t op, input logic d, input logic [4:0] f,
                      input logic [7:0] k);
    wr(ADR_CMD, {8'h00, k, 3'b000, f, 3'b000, d, op});
  endtask : exec

  function automatic logic [7:0] fadr(input logic [4:0] f);
    return {1'b1, f, 2'b00};
  endfunction : fadr

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(ADR_STATUS, 32'h18, "status after reset");
    rchk(ADR_W, 32'h0, "accumulator after reset");
    rchk(ADR_CMD, 32'h0, "command word reads zero");
    chk({24'h0, dir_a_out}, 32'hff, "direction 6 after reset");
    chk({24'h0, dir_b_out}, 32'hff, "direction 7 after reset");
    chk({31'h0, osc_run_out}, 32'h1, "running after reset");
  endtask : t_reset

  task automatic t_rotate();
    wr(fadr(5'h00), 32'h5a);
    wr(fadr(5'h1f), 32'h5b);
    wr(ADR_STATUS, 32'h87);
    exec(OP_ROT_L, 1'b0, 5'h00, 8'h00);
    rchk(ADR_W, 32'hb5, "rotate left into accumulator");
    rchk(fadr(5'h00), 32'h5a, "rotate left source kept");
    rchk(ADR_STATUS, 32'h86, "rotate left carry out");
    exec(OP_ROT_R, 1'b1, 5'h1f, 8'h00);
    rchk(fadr(5'h1f), 32'h2d, "rotate right into register");
    rchk(ADR_W, 32'hb5, "rotate right leaves accumulator");
    rchk(ADR_STATUS, 32'h87, "rotate right carry out");
  endtask : t_rotate

  // rows: nibble borrow, equal, underflow, no nibble borrow
  task automatic t_sub();
    logic [7:0] tf [4] = '{8'h10, 8'h3c, 8'h00, 8'h27};
    logic [7:0] tw [4] = '{8'h01, 8'h3c, 8'h01, 8'h15};
    logic [7:0] tr [4] = '{8'h0f, 8'h00, 8'hff, 8'h12};
    logic [2:0] fl [4] = '{3'b001, 3'b111, 3'b000, 3'b011};
    for (int i = 0; i < 4; i++) begin
      wr(fadr(5'h03), {24'h0, tf[i]});
      wr(ADR_W, {24'h0, tw[i]});
      wr(ADR_STATUS, 32'h80);
      exec(OP_SUB, 1'(i % 2), 5'h03, 8'h00);
      rchk(ADR_STATUS, {24'h0, 5'b10000, fl[i]}, "subtract flags");
      if (i % 2 == 1) begin
        rchk(fadr(5'h03), {24'h0, tr[i]}, "subtract into register");
        rchk(ADR_W, {24'h0, tw[i]}, "subtract keeps accumulator");
      end else begin
        rchk(ADR_W, {24'h0, tr[i]}, "subtract into accumulator");
        rchk(fadr(5'h03), {24'h0, tf[i]}, "subtract keeps register");
      end
    end
  endtask : t_sub

  task automatic t_swap();
    wr(fadr(5'h02), 32'ha5);
    wr(ADR_STATUS, 32'h87);
    exec(OP_SWAP, 1'b0, 5'h02, 8'h00);
    rchk(ADR_W, 32'h5a, "swap into accumulator");
    exec(OP_SWAP, 1'b1, 5'h02, 8'h00);
    rchk(fadr(5'h02), 32'h5a, "swap into register");
    rchk(ADR_STATUS, 32'h87, "swap leaves flags");
  endtask : t_swap

  // index 5 is not a direction register, so nothing may move
  task automatic t_dir();
    wr(ADR_STATUS, 32'h85);
    wr(ADR_W, 32'h3c);
    exec(OP_DIR_LOAD, 1'b0, 5'h06, 8'h00);
    chk({16'h0000, dir_a_out, dir_b_out}, 32'h3cff, "direction 6 load");
    wr(ADR_W, 32'hc3);
    exec(OP_DIR_LOAD, 1'b0, 5'h07, 8'h00);
    chk({16'h0000, dir_a_out, dir_b_out}, 32'h3cc3, "direction 7 load");
    wr(ADR_W, 32'h00);
    exec(OP_DIR_LOAD, 1'b0, 5'h05, 8'h00);
    chk({16'h0000, dir_a_out, dir_b_out}, 32'h3cc3, "index 5 ignored");
    rchk(ADR_STATUS, 32'h85, "direction load leaves flags");
  endtask : t_dir

  task automatic t_xor();
    wr(fadr(5'h04), 32'hff);
    wr(ADR_W, 32'hff);
    wr(ADR_STATUS, 32'h81);
    exec(OP_XOR_F, 1'b1, 5'h04, 8'h00);
    rchk(fadr(5'h04), 32'h00, "register xor into register");
    rchk(ADR_STATUS, 32'h85, "register xor zero set");
    exec(OP_XOR_F, 1'b0, 5'h04, 8'h00);
    rchk(ADR_W, 32'hff, "register xor into accumulator");
    rchk(ADR_STATUS, 32'h81, "register xor zero clear");
    exec(OP_XOR_K, 1'b0, 5'h00, 8'hff);
    rchk(ADR_W, 32'h00, "literal xor to zero");
    rchk(ADR_STATUS, 32'h85, "literal xor zero set");
    exec(OP_XOR_K, 1'b0, 5'h00, 8'ha5);
    rchk(ADR_W, 32'ha5, "literal xor value");
    rchk(ADR_STATUS, 32'h81, "literal xor zero clear");
  endtask : t_xor

  // the dog count only moves once its prescaler wraps, so let it run first
  task automatic t_sleep();
    wr(ADR_STATUS, 32'h8d);
    repeat (600) @(posedge sys_clk_in);
    bus(1'b0, DOG_ADR, 32'h0, rd_v);
    chk({31'h0, rd_v[7:0] != 8'h00}, 32'h1, "dog count has run");
    exec(OP_SLEEP, 1'b0, 5'h00, 8'h00);
    chk({31'h0, osc_run_out}, 32'h0, "oscillator stopped");
    bus(1'b0, DOG_ADR, 32'h0, rd_v);
    chk({24'h0, rd_v[7:0]}, 32'h0, "dog count cleared");
    chk({31'h0, rd_v[15:8] < 8'h08}, 32'h1, "prescaler cleared");
    rchk(ADR_STATUS, 32'h95, "sleep status bits");
    rchk(WAKE_ADR, 32'h1, "asleep flag");
    exec(OP_XOR_K, 1'b0, 5'h00, 8'hff);
    rchk(ADR_W, 32'ha5, "command ignored while asleep");
    rchk(8'h40, 32'h0, "unmapped address reads zero");
    wr(WAKE_ADR, 32'h1);
    chk({31'h0, osc_run_out}, 32'h1, "running after wake");
  endtask : t_sleep

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_rotate();
    t_sub();
    t_swap();
    t_dir();
    t_xor();
    t_sleep();
    stop_test();
  end
endmodule : exec_unit_tb
`default_nettype wire
